/* File: src/gmp_pin_map.svh */
/*
 * Constants for the PHY-side pin logic: widths, nibble positions and idle values.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef GMP_PIN_MAP_SVH
`define GMP_PIN_MAP_SVH

`define GMP_BYTE_W 8
`define GMP_NIB_W 4
`define GMP_HI_NIB 7:4
`define GMP_LO_NIB 3:0
`define GMP_ZERO_BYTE 8'h00
`define GMP_ZERO_NIB 4'h0
`define GMP_TX_WORD_W 9
`define GMP_TX_ERR_BIT 8
`define GMP_BUF_DEPTH 2'h2
`define GMP_TX_CLK_1G_MHZ 125
`define GMP_TX_CLK_100M_MHZ 12.5
`define GMP_TX_CLK_10M_MHZ 1.25

`endif

/* File: src/gmp_pkg.sv */
/*
 * Types shared by the PHY-side pin logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gmp_pkg;

	// Receive byte assembly for the 10/100 double-edge pins
	typedef enum logic [1:0] {
		GMP_RX_WAIT_RISE = 2'b01,
		GMP_RX_WAIT_FALL = 2'b10
	} gmp_rx_state_t;

endpackage

/* File: src/gmp_buf2.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset; the ready output is registered.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gmp_pin_map.svh"

module gmp_buf2 #(
	parameter int W = `GMP_TX_WORD_W
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [W-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [W-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	logic [W-1:0] mem_r [2];
	logic wr_ptr_r;
	logic rd_ptr_r;
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	assign out_valid_out = (cnt_r != 2'h0);
	assign out_data_out = mem_r[rd_ptr_r];

	// Occupancy after this cycle
	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	// Pointers, count and a registered ready so the source sees a clean level
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			cnt_r <= 2'h0;
			in_ready_out <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			in_ready_out <= (cnt_nxt != `GMP_BUF_DEPTH);
			if (push) begin
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop) begin
				rd_ptr_r <= ~rd_ptr_r;
			end
		end
	end

	// Storage, one entry per slot
	for (genvar i = 0; i < 2; i++) begin : g_slot
		always_ff @(posedge clk_in) begin
			if (push && (wr_ptr_r == 1'(i))) begin
				mem_r[i] <= in_data_in;
			end
		end
	end
endmodule // gmp_buf2

`default_nettype wire

/* File: src/gmp_phy_pins.sv */
/*
 * PHY-side pin logic of a tri-speed Ethernet MAC: management output and its drive
 * enable, transmit data/enable/error pins, and receive data/valid capture.
 * Assumes the transmit and receive MAC clocks arrive as plain pins that CLK_IN
 * oversamples, and that mode and option straps hold still while frames run.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gmp_pin_map.svh"

// Operation
// - The management drive enable is high exactly while the management output carries a valid bit.
// - In 1G mode the upper transmit nibble goes out on rising-edge bits 7 to 4.
// - In 10/100 mode rising-edge bits 7 to 4 are unused and held at zero.
// - In 1G mode the rising and falling lower nibbles carry the same value every cycle.
// - In 10/100 mode the byte's high nibble goes on the rising lower lanes and its low nibble on the falling ones.
// - The transmit clock runs at 125 MHz in 1G, 12.5 MHz at 100 Mb/s and 1.25 MHz at 10 Mb/s.
// - Transmit enable is high exactly for the cycles in which the data pins hold frame content.
// - Transmit error is high on a byte that the MAC deliberately marks as a coding error.
// - Receive data and valid pass two CLK_IN synchroniser stages before the core sees them.
// - With double-edge pins, rising inputs are sampled on the receive clock rise and, at 10/100 only, falling ones on its fall.
// - Separate rising and falling valid inputs are used only with double-edge pins, else the single valid.
// - Without double-edge pins each byte goes out whole on the single 8-bit transmit bus.
module gmp_phy_pins
	import gmp_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic GIG_MODE_IN,
	input wire logic DDR_PINS_IN,
	input wire logic MGMT_BIT_IN,
	input wire logic MGMT_BIT_VALID_IN,
	output logic MGMT_DATA_OUT,
	output logic MGMT_DRIVE_EN_OUT,
	input wire logic [`GMP_BYTE_W-1:0] TX_DATA_IN,
	input wire logic TX_ERR_IN,
	input wire logic TX_VALID_IN,
	output logic TX_READY_OUT,
	input wire logic TX_CLK_IN,
	output logic [`GMP_BYTE_W-1:0] TXD_POS_OUT,
	output logic [`GMP_NIB_W-1:0] TXD_NEG_OUT,
	output logic [`GMP_BYTE_W-1:0] TXD_OUT,
	output logic TXEN_OUT,
	output logic TXER_OUT,
	input wire logic RX_CLK_IN,
	input wire logic [`GMP_BYTE_W-1:0] RXD_POS_IN,
	input wire logic [`GMP_NIB_W-1:0] RXD_NEG_IN,
	input wire logic [`GMP_BYTE_W-1:0] RXD_IN,
	input wire logic RXDV_POS_IN,
	input wire logic RXDV_NEG_IN,
	input wire logic RXDV_IN,
	output logic [`GMP_BYTE_W-1:0] RX_DATA_OUT,
	output logic RX_VALID_OUT
);
	logic gig_r;
	logic ddr_r;
	logic [`GMP_TX_WORD_W-1:0] buf_data;
	logic buf_valid;
	logic buf_ready;
	logic [`GMP_BYTE_W-1:0] tx_byte;
	logic tx_clk_s1_r, tx_clk_s2_r, tx_clk_d_r;
	logic tx_rise;
	logic rx_clk_s1_r, rx_clk_s2_r, rx_clk_d_r;
	logic rx_rise;
	logic rx_fall;
	logic [`GMP_BYTE_W-1:0] rxd_pos_s1_r, rxd_pos_s2_r, rxd_s1_r, rxd_s2_r;
	logic [`GMP_NIB_W-1:0] rxd_neg_s1_r, rxd_neg_s2_r;
	logic dv_pos_s1_r, dv_pos_s2_r, dv_neg_s1_r, dv_neg_s2_r, dv_s1_r, dv_s2_r;
	logic [`GMP_NIB_W-1:0] rx_hi_r;
	logic rx_hi_dv_r;
	gmp_rx_state_t rx_state_r;

	// Straps are caught by a clocked process, never through the reset itself
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			gig_r <= 1'b0;
			ddr_r <= 1'b0;
		end else begin
			gig_r <= GIG_MODE_IN;
			ddr_r <= DDR_PINS_IN;
		end
	end

	// Management bit and its drive enable leave in the same cycle, so the pin never glitches
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			MGMT_DATA_OUT <= 1'b0;
			MGMT_DRIVE_EN_OUT <= 1'b0;
		end else begin
			MGMT_DATA_OUT <= MGMT_BIT_IN;
			MGMT_DRIVE_EN_OUT <= MGMT_BIT_VALID_IN;
		end
	end

	// Transmit words wait here so the core may run ahead of the slow link clock
	gmp_buf2 #(
		.W(`GMP_TX_WORD_W)
	) u_tx_buf (
		.clk_in(CLK_IN),
		.rst_b_in(RST_B_IN),
		.in_data_in({TX_ERR_IN, TX_DATA_IN}),
		.in_valid_in(TX_VALID_IN),
		.in_ready_out(TX_READY_OUT),
		.out_data_out(buf_data),
		.out_valid_out(buf_valid),
		.out_ready_in(buf_ready)
	);

	// Transmit clock pin synchroniser; only the second stage feeds the edge finder.
	// Left without reset so the chain keeps tracking the pin: a link clock that is
	// high at release must not look like a fresh rise.
	always_ff @(posedge CLK_IN) begin
		tx_clk_s1_r <= TX_CLK_IN;
		tx_clk_s2_r <= tx_clk_s1_r;
		tx_clk_d_r <= tx_clk_s2_r;
	end

	// One byte per transmit clock rise; the pin is oversampled the same way at every rate
	assign tx_rise = tx_clk_s2_r & ~tx_clk_d_r;
	assign buf_ready = tx_rise;
	assign tx_byte = buf_data[`GMP_BYTE_W-1:0];

	// Pin drive: enable and error follow the word, data idles at zero between frames
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			TXD_POS_OUT <= `GMP_ZERO_BYTE;
			TXD_NEG_OUT <= `GMP_ZERO_NIB;
			TXD_OUT <= `GMP_ZERO_BYTE;
			TXEN_OUT <= 1'b0;
			TXER_OUT <= 1'b0;
		end else if (tx_rise) begin
			TXEN_OUT <= buf_valid;
			TXER_OUT <= buf_valid & buf_data[`GMP_TX_ERR_BIT];
			TXD_POS_OUT <= `GMP_ZERO_BYTE;
			TXD_NEG_OUT <= `GMP_ZERO_NIB;
			TXD_OUT <= `GMP_ZERO_BYTE;
			if (buf_valid && ddr_r && gig_r) begin
				TXD_POS_OUT[`GMP_HI_NIB] <= tx_byte[`GMP_HI_NIB];
				TXD_POS_OUT[`GMP_LO_NIB] <= tx_byte[`GMP_LO_NIB];
				TXD_NEG_OUT <= tx_byte[`GMP_LO_NIB];
			end else if (buf_valid && ddr_r) begin
				TXD_POS_OUT[`GMP_HI_NIB] <= `GMP_ZERO_NIB;
				TXD_POS_OUT[`GMP_LO_NIB] <= tx_byte[`GMP_HI_NIB];
				TXD_NEG_OUT <= tx_byte[`GMP_LO_NIB];
			end else if (buf_valid) begin
				TXD_OUT <= tx_byte;
			end
		end
	end

	// Receive clock pin synchroniser and edge finder; no reset, so no false edge after release
	always_ff @(posedge CLK_IN) begin
		rx_clk_s1_r <= RX_CLK_IN;
		rx_clk_s2_r <= rx_clk_s1_r;
		rx_clk_d_r <= rx_clk_s2_r;
	end

	assign rx_rise = rx_clk_s2_r & ~rx_clk_d_r;
	assign rx_fall = ~rx_clk_s2_r & rx_clk_d_r;

	// Receive pins pass the same two stages as the clock so edges and data stay aligned
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			rxd_pos_s1_r <= `GMP_ZERO_BYTE;
			rxd_pos_s2_r <= `GMP_ZERO_BYTE;
			rxd_neg_s1_r <= `GMP_ZERO_NIB;
			rxd_neg_s2_r <= `GMP_ZERO_NIB;
			rxd_s1_r <= `GMP_ZERO_BYTE;
			rxd_s2_r <= `GMP_ZERO_BYTE;
			dv_pos_s1_r <= 1'b0;
			dv_pos_s2_r <= 1'b0;
			dv_neg_s1_r <= 1'b0;
			dv_neg_s2_r <= 1'b0;
			dv_s1_r <= 1'b0;
			dv_s2_r <= 1'b0;
		end else begin
			rxd_pos_s1_r <= RXD_POS_IN;
			rxd_pos_s2_r <= rxd_pos_s1_r;
			rxd_neg_s1_r <= RXD_NEG_IN;
			rxd_neg_s2_r <= rxd_neg_s1_r;
			rxd_s1_r <= RXD_IN;
			rxd_s2_r <= rxd_s1_r;
			dv_pos_s1_r <= RXDV_POS_IN;
			dv_pos_s2_r <= dv_pos_s1_r;
			dv_neg_s1_r <= RXDV_NEG_IN;
			dv_neg_s2_r <= dv_neg_s1_r;
			dv_s1_r <= RXDV_IN;
			dv_s2_r <= dv_s1_r;
		end
	end

	// Byte assembly; a 10/100 byte is released only when both halves were valid
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			rx_state_r <= GMP_RX_WAIT_RISE;
			rx_hi_r <= `GMP_ZERO_NIB;
			rx_hi_dv_r <= 1'b0;
			RX_DATA_OUT <= `GMP_ZERO_BYTE;
			RX_VALID_OUT <= 1'b0;
		end else begin
			RX_VALID_OUT <= 1'b0;
			case (rx_state_r)
				GMP_RX_WAIT_RISE: begin
					if (rx_rise && ddr_r && !gig_r) begin
						rx_hi_r <= rxd_pos_s2_r[`GMP_LO_NIB];
						rx_hi_dv_r <= dv_pos_s2_r;
						rx_state_r <= GMP_RX_WAIT_FALL;
					end else if (rx_rise && ddr_r && dv_pos_s2_r) begin
						RX_DATA_OUT <= rxd_pos_s2_r;
						RX_VALID_OUT <= 1'b1;
					end else if (rx_rise && !ddr_r && dv_s2_r) begin
						RX_DATA_OUT <= rxd_s2_r;
						RX_VALID_OUT <= 1'b1;
					end
				end
				GMP_RX_WAIT_FALL: begin
					if (rx_fall) begin
						rx_state_r <= GMP_RX_WAIT_RISE;
						if (rx_hi_dv_r && dv_neg_s2_r) begin
							RX_DATA_OUT <= {rx_hi_r, rxd_neg_s2_r};
							RX_VALID_OUT <= 1'b1;
						end
					end
				end
				default: begin
					rx_state_r <= GMP_RX_WAIT_RISE;
				end
			endcase
		end
	end
endmodule // gmp_phy_pins

`default_nettype wire

/* File: sim/gmp_phy_pins_props.sv */
/* Concurrent checks on the ports of the PHY-side pin logic.
   Assumes mode straps stay still outside reset. */
`timescale 1ns/1ps
`default_nettype none
module gmp_phy_pins_props (
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic GIG_MODE_IN,
	input wire logic DDR_PINS_IN,
	input wire logic MGMT_BIT_IN,
	input wire logic MGMT_BIT_VALID_IN,
	input wire logic MGMT_DATA_OUT,
	input wire logic MGMT_DRIVE_EN_OUT,
	input wire logic TX_CLK_IN,
	input wire logic [7:0] TXD_POS_OUT,
	input wire logic [3:0] TXD_NEG_OUT,
	input wire logic [7:0] TXD_OUT,
	input wire logic TXEN_OUT,
	input wire logic TXER_OUT,
	input wire logic RX_VALID_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	// The first edge after release still shows reset values, hence the past guard
	mgmt_data_a: assert property ($past(RST_B_IN) |-> MGMT_DATA_OUT == $past(MGMT_BIT_IN))
		else $error("mgmt data lag wrong");
	mgmt_en_a: assert property ($past(RST_B_IN) |-> MGMT_DRIVE_EN_OUT == $past(MGMT_BIT_VALID_IN))
		else $error("mgmt enable lag wrong");
	slow_hi_a: assert property (DDR_PINS_IN && !GIG_MODE_IN |-> TXD_POS_OUT[7:4] == 4'h0)
		else $error("upper rising lanes used");
	gig_lo_a: assert property (DDR_PINS_IN && GIG_MODE_IN |-> TXD_POS_OUT[3:0] == TXD_NEG_OUT)
		else $error("lower nibbles differ");
	one_bus_a: assert property (DDR_PINS_IN ? TXD_OUT == 8'h00 : {TXD_POS_OUT, TXD_NEG_OUT} == 12'h000)
		else $error("wrong transmit bus used");
	idle_pins_a: assert property (!TXEN_OUT |-> {TXD_OUT, TXD_POS_OUT, TXD_NEG_OUT, TXER_OUT} == 21'h0)
		else $error("pins active while idle");
	// Pins may only move on a detected link clock rise
	tx_on_rise_a: assert property (
		!$stable({TXEN_OUT, TXER_OUT, TXD_OUT, TXD_POS_OUT, TXD_NEG_OUT})
		|-> TX_CLK_IN && $past(TX_CLK_IN, 2))
		else $error("pins moved off link rise");
	rx_pulse_a: assert property (RX_VALID_OUT |=> !RX_VALID_OUT [*6])
		else $error("receive pulses too close");
endmodule // gmp_phy_pins_props

bind gmp_phy_pins gmp_phy_pins_props props_u (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
	.GIG_MODE_IN(GIG_MODE_IN), .DDR_PINS_IN(DDR_PINS_IN), .MGMT_BIT_IN(MGMT_BIT_IN),
	.MGMT_BIT_VALID_IN(MGMT_BIT_VALID_IN), .MGMT_DATA_OUT(MGMT_DATA_OUT),
	.MGMT_DRIVE_EN_OUT(MGMT_DRIVE_EN_OUT), .TX_CLK_IN(TX_CLK_IN), .TXD_POS_OUT(TXD_POS_OUT),
	.TXD_NEG_OUT(TXD_NEG_OUT), .TXD_OUT(TXD_OUT), .TXEN_OUT(TXEN_OUT), .TXER_OUT(TXER_OUT),
	.RX_VALID_OUT(RX_VALID_OUT));
`default_nettype wire

/* File: sim/gmp_phy_model.sv */
/* PHY model: link clocks, transmit pin capture, receive pin driver.
   Assumes the bench's straps match the design's. */
`timescale 1ns/1ps
`default_nettype none
module gmp_phy_model (
	input wire logic gig_in,
	output logic tx_clk_out,
	output logic rx_clk_out,
	input wire logic [7:0] txd_pos_in,
	input wire logic [3:0] txd_neg_in,
	input wire logic [7:0] txd_in,
	input wire logic txer_in,
	input wire logic txen_in,
	output logic [7:0] rxd_pos_out,
	output logic [3:0] rxd_neg_out,
	output logic [7:0] rxd_out,
	output logic rxdv_pos_out,
	output logic rxdv_neg_out,
	output logic rxdv_out
);
	logic [20:0] cap_q[$];
	initial begin
		{tx_clk_out, rx_clk_out, rxdv_pos_out, rxdv_neg_out, rxdv_out} = 5'h0;
		{rxd_pos_out, rxd_neg_out, rxd_out} = 20'h0;
	end
	// Free-running 800 ns link clocks
	always #400 tx_clk_out = ~tx_clk_out;
	always #400 rx_clk_out = ~rx_clk_out;
	// Pins taken mid-bit, well after the core's rise-detect lag
	always @(negedge tx_clk_out) begin
		if (txen_in) cap_q.push_back({txer_in, txd_in, txd_pos_in, txd_neg_in});
	end
	// Rising-edge pins set half a period early, falling-edge pins at the rise
	task automatic send(input logic [7:0] b, input logic v);
		@(negedge rx_clk_out);
		rxd_out = b;
		rxd_pos_out = gig_in ? b : {b[3:0], b[7:4]};
		rxdv_out = v;
		rxdv_pos_out = v;
		@(posedge rx_clk_out);
		rxd_neg_out = b[3:0];
		rxdv_neg_out = v;
	endtask
endmodule // gmp_phy_model
`default_nettype wire

/* File: sim/tb.sv */
/* Self-checking bench for the PHY-side pin logic in all four strap settings.
   Assumes the PHY model supplies link clocks and receive pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'h0, rst_b = 1'h0, gig = 1'h0, ddr = 1'h0, mb = 1'h0, mv = 1'h0, ter = 1'h0, tv = 1'h0;
	logic [7:0] td = 8'h00, rnd = 8'h29, mr = 8'h29;
	wire [7:0] tpos, txd, rxd_p, rxd, rdat;
	wire [3:0] tneg, rxd_n;
	wire mdo, men, trdy, txen, txer, tclk, rclk, dvp, dvn, dv, rval;
	logic [8:0] exq[$];
	logic [7:0] rxq[$], gotq[$];
	int miscompares = 0, checked = 0, refused = 0;
	gmp_phy_pins dut_u (.CLK_IN(clk), .RST_B_IN(rst_b), .GIG_MODE_IN(gig), .DDR_PINS_IN(ddr),
		.MGMT_BIT_IN(mb), .MGMT_BIT_VALID_IN(mv), .MGMT_DATA_OUT(mdo), .MGMT_DRIVE_EN_OUT(men),
		.TX_DATA_IN(td), .TX_ERR_IN(ter), .TX_VALID_IN(tv), .TX_READY_OUT(trdy), .TX_CLK_IN(tclk),
		.TXD_POS_OUT(tpos), .TXD_NEG_OUT(tneg), .TXD_OUT(txd), .TXEN_OUT(txen), .TXER_OUT(txer),
		.RX_CLK_IN(rclk), .RXD_POS_IN(rxd_p), .RXD_NEG_IN(rxd_n), .RXD_IN(rxd), .RXDV_POS_IN(dvp),
		.RXDV_NEG_IN(dvn), .RXDV_IN(dv), .RX_DATA_OUT(rdat), .RX_VALID_OUT(rval));
	gmp_phy_model phy_u (.gig_in(gig), .tx_clk_out(tclk), .rx_clk_out(rclk), .txd_pos_in(tpos),
		.txd_neg_in(tneg), .txd_in(txd), .txer_in(txer), .txen_in(txen), .rxd_pos_out(rxd_p),
		.rxd_neg_out(rxd_n), .rxd_out(rxd), .rxdv_pos_out(dvp), .rxdv_neg_out(dvn), .rxdv_out(dv));
	always #50 clk = ~clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Expected pins {err, single bus, rising lanes, falling lanes} for a word
	function automatic logic [20:0] pins(input logic [8:0] w);
		if (!ddr) return {w[8], w[7:0], 12'h000};
		if (gig) return {w[8], 8'h00, w[7:0], w[3:0]};
		return {w[8], 8'h00, 4'h0, w[7:4], w[3:0]};
	endfunction
	task automatic summarize;
		$display("miscompares %0d checked %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Management bits are redrawn from the LFSR every cycle so a stuck or late copy shows
	always @(negedge clk) begin
		mr <= lfsr(mr);
		{mb, mv} <= mr[1:0];
	end
	always @(negedge clk) begin
		if (rst_b && rval === 1'h1) gotq.push_back(rdat);
	end
	initial begin
		logic [8:0] w;
		int n;
		for (int m = 0; m < 4; m++) begin
			{ddr, gig} = 2'(m);
			rst_b = 1'h0;
			repeat (5) @(negedge clk);
			rst_b = 1'h1;
			repeat (2) @(negedge clk);
			exq.delete();
			rxq.delete();
			gotq.delete();
			phy_u.cap_q.delete();
			refused = 0;
			// Words offered every cycle overrun the buffer, so ready must refuse
			for (int i = 0; i < 12; i++) begin
				rnd = lfsr(rnd);
				w = (i == 0) ? 9'h1ff : (i == 1) ? 9'h00f : {rnd[3] ^ rnd[6], rnd};
				exq.push_back(w);
				{ter, td} = w;
				tv = 1'h1;
				for (n = 0; n < 200 && trdy !== 1'h1; n++) @(negedge clk);
				if (n == 200) begin
					miscompares++;
					summarize;
				end
				if (n > 0) refused++;
				@(negedge clk);
			end
			tv = 1'h0;
			// A full buffer must have held the source off at least once
			chk(21'(refused > 0), 21'h1);
			// Bytes with valid low, mid-run and last, must produce nothing
			for (int i = 0; i < 11; i++) begin
				rnd = lfsr(rnd);
				if (i != 4 && i != 10) rxq.push_back(rnd);
				phy_u.send(rnd, i != 4 && i != 10);
			end
			repeat (30) @(negedge clk);
			chk(21'(phy_u.cap_q.size()), 21'(exq.size()));
			foreach (exq[i]) chk(phy_u.cap_q[i], pins(exq[i]));
			chk(21'(gotq.size()), 21'(rxq.size()));
			foreach (rxq[i]) chk(21'(gotq[i]), 21'(rxq[i]));
		end
		summarize;
	end
endmodule // tb
`default_nettype wire
